// ==== core/ssp_port.sv ====
// Synchronous serial port top: registers, buffers, master and slave frame engine.
// ==========================================================================
`timescale 1ns/1ps
module ssp_port #(
  parameter int FIFO_DEPTH = ssp_pkg::FIFO_DPTH
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Register port
  input  wire logic [ssp_pkg::ADDR_W-1:0] addr,
  input  wire logic [ssp_pkg::DATA_W-1:0] writeData,
  input  wire logic                       writeStrobe,
  input  wire logic                       readStrobe,
  output logic      [ssp_pkg::DATA_W-1:0] readData,
  // Serial clock pin
  input  wire logic                       sclkIn,
  output logic                            sclkOut,
  output logic                            sclkOe,
  // Frame pin
  input  wire logic                       frameIn,
  output logic                            frameOut,
  output logic                            frameOe,
  // Serial data pins
  input  wire logic                       rxdIn,
  output logic                            txdOut,
  output logic                            txdOe
);
  localparam int DW = ssp_pkg::DATA_W;
  localparam int CW = ssp_pkg::CNT_W;

  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_SHIFT, ST_END} ssp_state_e;

  // ==========================================================================
  // Registers
  logic [DW-1:0] ctrl0;
  logic [2:0]    ctrl1;
  logic [7:0]    prescale;
  logic          overrun;

  wire [CW-1:0] widM1     = {1'b0, ctrl0[ssp_pkg::C0_WID_MSB:ssp_pkg::C0_WID_LSB]};
  wire [CW-1:0] width     = (widM1 < ssp_pkg::MIN_WID_M1) ? ssp_pkg::MIN_WID_M1 + 5'h01
                                                          : widM1 + 5'h01;
  wire [1:0]    fmt       = ctrl0[ssp_pkg::C0_FMT_MSB:ssp_pkg::C0_FMT_LSB];
  wire          cpol      = (fmt == ssp_pkg::FMT_SPI) && ctrl0[ssp_pkg::C0_CPOL];
  wire          cpha      = (fmt == ssp_pkg::FMT_SPI) && ctrl0[ssp_pkg::C0_CPHA];
  wire [7:0]    scr       = ctrl0[ssp_pkg::C0_SCR_MSB:ssp_pkg::C0_SCR_LSB];
  wire          enable    = ctrl1[ssp_pkg::C1_EN];
  wire          slave     = ctrl1[ssp_pkg::C1_SLAVE];
  wire          sod       = ctrl1[ssp_pkg::C1_SOD];
  wire          isMw      = (fmt == ssp_pkg::FMT_MW);
  wire          levelA    = cpol ^ cpha;  // clock level in the drive half of a bit
  wire          master    = enable && !slave;

  // Address decode
  wire selCtrl0 = (addr == ssp_pkg::OFF_CTRL0);
  wire selCtrl1 = (addr == ssp_pkg::OFF_CTRL1);
  wire selData  = (addr == ssp_pkg::OFF_DATA);
  wire selStat  = (addr == ssp_pkg::OFF_STATUS);
  wire selPre   = (addr == ssp_pkg::OFF_PRESCALE);

  // ==========================================================================
  // Buffers
  logic          txValid;
  logic [DW-1:0] txWord;
  logic          txPop;
  logic          txReady;
  logic          rxValid;
  logic [DW-1:0] rxWord;
  logic          rxReady;
  logic          rxPush;
  logic [DW-1:0] rxPushData;

  wire txWrite = writeStrobe && selData;
  wire rxRead  = readStrobe && selData;

  // Writes to a full transmit buffer are dropped
  ssp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) txFifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (txWrite),
    .inData   (writeData),
    .inReady  (txReady),
    .outValid (txValid),
    .outData  (txWord),
    .outReady (txPop)
  );

  ssp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (rxPush),
    .inData   (rxPushData),
    .inReady  (rxReady),
    .outValid (rxValid),
    .outData  (rxWord),
    .outReady (rxRead)
  );

  // ==========================================================================
  // Rate generator
  logic tick;

  ssp_rate rate (
    .clk      (clk),
    .rst      (rst),
    .run      (master),
    .prescale (prescale),
    .scr      (scr),
    .tick     (tick)
  );

  // ==========================================================================
  // Pin synchronisers: three stages, a change counts when stages two and three agree
  logic [ssp_pkg::SYNC_LEN-1:0] syncS;
  logic [ssp_pkg::SYNC_LEN-1:0] syncF;
  logic [ssp_pkg::SYNC_LEN-1:0] syncR;
  logic                         sclkLvl;
  logic                         frameLvl;
  logic                         rxdLvl;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncS <= '0;
      syncF <= '1;
      syncR <= '0;
    end else begin
      syncS <= {syncS[1:0], sclkIn};
      syncF <= {syncF[1:0], frameIn};
      syncR <= {syncR[1:0], rxdIn};
    end
  end

  wire sclkOk   = (syncS[1] == syncS[2]);
  wire frameOk  = (syncF[1] == syncF[2]);
  wire sclkChg  = sclkOk && (syncS[2] != sclkLvl);
  wire frameFall = frameOk && !syncF[2] && frameLvl;
  wire frameRise = frameOk && syncF[2] && !frameLvl;
  wire sEdgeSmp = sclkChg && (syncS[2] != levelA);
  wire sEdgeDrv = sclkChg && (syncS[2] == levelA);

  // Filtered levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclkLvl  <= 1'b0;
      frameLvl <= 1'b1;
      rxdLvl   <= 1'b0;
    end else begin
      if (sclkOk) sclkLvl <= syncS[2];
      if (frameOk) frameLvl <= syncF[2];
      if (syncR[1] == syncR[2]) rxdLvl <= syncR[2];
    end
  end

  // ==========================================================================
  // Frame engine
  ssp_state_e    state;
  logic          halfB;
  logic          sActive;
  logic          sampled;
  logic [CW-1:0] bitCnt;
  logic [DW-1:0] shTx;
  logic [DW-1:0] shRx;

  // Command-reply format sends an 8-bit command, then receives a full reply word
  wire [CW-1:0] totalBits = isMw ? ssp_pkg::MW_CMD + width : width;
  wire          rxBitOn   = !isMw || (bitCnt >= ssp_pkg::MW_CMD);
  wire [DW-1:0] wordMask  = DW'((17'h00001 << width) - 17'h00001);
  wire [DW-1:0] txAlign   = isMw ? (txWord << ssp_pkg::MW_CMD) : (txWord << (5'h10 - width));
  wire [DW-1:0] shRxNext  = {shRx[DW-2:0], rxdLvl};
  wire          frameIdle = (fmt != ssp_pkg::FMT_SSF);  // high idle except SSF
  // Master holds off a new frame while the receive buffer is full
  wire          mStart    = master && tick && txValid && rxReady;

  assign txPop = (state == ST_IDLE && mStart) || (slave && enable && frameFall && txValid);

  // Master sequencing on half-bit ticks, slave sequencing on synchronised edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= ST_IDLE;
      halfB      <= 1'b0;
      sActive    <= 1'b0;
      sampled    <= 1'b0;
      bitCnt     <= '0;
      shTx       <= '0;
      shRx       <= '0;
      rxPush     <= 1'b0;
      rxPushData <= '0;
      overrun    <= 1'b0;
      sclkOut    <= 1'b0;
      frameOut   <= 1'b1;
    end else begin
      rxPush <= 1'b0;
      if (writeStrobe && selStat && writeData[ssp_pkg::ST_ROR]) overrun <= 1'b0;
      if (!enable) begin
        state    <= ST_IDLE;
        sActive  <= 1'b0;
        sclkOut  <= cpol;
        frameOut <= frameIdle;
      end else if (!slave) begin
        sActive <= 1'b0;
        case (state)
          ST_IDLE: begin
            sclkOut  <= cpol;
            frameOut <= frameIdle;
            if (mStart) begin
              shTx   <= txAlign;
              bitCnt <= '0;
              halfB  <= 1'b0;
              state  <= (fmt == ssp_pkg::FMT_SSF) ? ST_PULSE : ST_SHIFT;
              // SSF raises the frame pin for one bit before the data
              frameOut <= (fmt == ssp_pkg::FMT_SSF);
              if (fmt != ssp_pkg::FMT_SSF) sclkOut <= levelA;
            end
          end
          ST_PULSE: if (tick) begin
            halfB <= !halfB;
            if (halfB) begin
              frameOut <= 1'b0;
              sclkOut  <= levelA;
              state    <= ST_SHIFT;
            end
          end
          ST_SHIFT: if (tick) begin
            halfB <= !halfB;
            if (!halfB) begin
              sclkOut <= !levelA;
              if (rxBitOn) shRx <= shRxNext;
            end else if (bitCnt == totalBits - 5'h01) begin
              state <= ST_END;
            end else begin
              sclkOut <= levelA;
              bitCnt  <= bitCnt + 5'h01;
              shTx    <= {shTx[DW-2:0], 1'b0};
            end
          end
          ST_END: if (tick) begin
            rxPush     <= 1'b1;
            rxPushData <= shRx & wordMask;
            sclkOut    <= cpol;
            frameOut   <= frameIdle;
            state      <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end else begin
        state <= ST_IDLE;
        // Slave: frame starts on the falling frame pin in every format
        if (frameFall) begin
          sActive <= 1'b1;
          sampled <= 1'b0;
          bitCnt  <= '0;
          shTx    <= txValid ? (txWord << (5'h10 - width)) : '0;
        end else if (sActive) begin
          if (frameRise && fmt == ssp_pkg::FMT_SPI) begin
            sActive <= 1'b0;
          end else if (sEdgeSmp) begin
            sampled <= 1'b1;
            shRx    <= shRxNext;
            if (bitCnt == width - 5'h01) begin
              sActive    <= 1'b0;
              rxPush     <= rxReady;
              rxPushData <= shRxNext & wordMask;
              if (!rxReady) overrun <= 1'b1;
            end
            bitCnt <= bitCnt + 5'h01;
          end else if (sEdgeDrv && sampled) begin
            shTx    <= {shTx[DW-2:0], 1'b0};
            sampled <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Pin drivers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclkOe <= 1'b0;
      frameOe <= 1'b0;
      txdOut <= 1'b0;
      txdOe  <= 1'b0;
    end else begin
      sclkOe  <= master;
      frameOe <= master;
      txdOut  <= shTx[DW-1];
      // Command-reply master releases data only while reply bits shift in
      txdOe   <= master ? !(isMw && bitCnt >= ssp_pkg::MW_CMD && state == ST_SHIFT)
                        : (slave && enable && sActive && !sod);
    end
  end

  // ==========================================================================
  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl0    <= ssp_pkg::CTRL0_RST;
      ctrl1    <= ssp_pkg::CTRL1_RST;
      prescale <= ssp_pkg::PRESCALE_RST;
    end else if (writeStrobe) begin
      if (selCtrl0) ctrl0 <= writeData;
      if (selCtrl1) ctrl1 <= writeData[2:0];
      if (selPre) prescale <= writeData[7:0];
    end
  end

  // Status word gathered from live buffer and engine state
  wire busy = (state != ST_IDLE) || sActive || txValid;
  wire [DW-1:0] statusWord = {10'h000, overrun, busy, !rxReady, rxValid, txReady,
                              !txValid};

  wire [DW-1:0] readMux = selCtrl0 ? ctrl0 :
                          selCtrl1 ? {13'h0000, ctrl1} :
                          selData  ? (rxValid ? rxWord : 16'h0000) :
                          selStat  ? statusWord :
                          selPre   ? {8'h00, prescale} : 16'h0000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readData <= '0;
    end else begin
      readData <= readStrobe ? readMux : '0;
    end
  end
endmodule // ssp_port

// ==== inc/ssp_pkg.sv ====
// Shared constants for the synchronous serial port: register map, fields, resets, formats.
package ssp_pkg;

  // ==========================================================================
  // Widths
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 8;
  localparam int CNT_W     = 5;
  localparam int FIFO_DPTH = 8;
  localparam int SYNC_LEN  = 3;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_CTRL0    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL1    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DATA     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int C0_WID_LSB = 0;   // frame width minus one, 4 bits
  localparam int C0_WID_MSB = 3;
  localparam int C0_FMT_LSB = 4;   // frame format, 2 bits
  localparam int C0_FMT_MSB = 5;
  localparam int C0_CPOL    = 6;   // idle clock level
  localparam int C0_CPHA    = 7;   // sample on second edge
  localparam int C0_SCR_LSB = 8;   // bit-rate divider, 8 bits
  localparam int C0_SCR_MSB = 15;
  localparam int C1_EN      = 0;   // port enable
  localparam int C1_SLAVE   = 1;   // slave mode
  localparam int C1_SOD     = 2;   // slave output disable
  localparam int ST_TXE     = 0;
  localparam int ST_TNF     = 1;
  localparam int ST_RNE     = 2;
  localparam int ST_RFF     = 3;
  localparam int ST_BSY     = 4;
  localparam int ST_ROR     = 5;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] CTRL0_RST    = 16'h0007;
  localparam logic [2:0]        CTRL1_RST    = 3'h0;
  localparam logic [7:0]        PRESCALE_RST = 8'h02;

  // ==========================================================================
  // Frame formats
  localparam logic [1:0] FMT_SPI = 2'h0;
  localparam logic [1:0] FMT_SSF = 2'h1;
  localparam logic [1:0] FMT_MW  = 2'h2;

  // ==========================================================================
  // Frame sizes
  localparam logic [CNT_W-1:0] MIN_WID_M1 = 5'h03;
  localparam logic [CNT_W-1:0] MW_CMD     = 5'h08;

endpackage

// ==== core/ssp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [CW-1:0]    count;
  wire              doPush = inValid && inReady;
  wire              doPop  = outValid && outReady;

  // Full and empty straight from the occupancy count
  assign inReady  = (count != CW'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  // Storage array carries no reset; only pointers and count need it
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + CW'(doPush) - CW'(doPop);
    end
  end
endmodule // ssp_fifo

// ==== core/ssp_rate.sv ====
// Serial clock rate generator: prescaler then bit-rate divider, half-bit tick out.
`timescale 1ns/1ps
module ssp_rate (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Settings
  input  wire logic       run,
  input  wire logic [7:0] prescale,
  input  wire logic [7:0] scr,
  // Half-bit enable pulse
  output logic            tick
);
  logic [7:0] preCnt;
  logic [7:0] divCnt;
  wire        preLast = (preCnt + 8'h01 >= prescale);  // zero acts as one
  wire        divLast = (divCnt >= scr);  // a lowered divider never wraps round

  // Tick every prescale*(scr+1) cycles; held clear while stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preCnt <= 8'h00;
      divCnt <= 8'h00;
      tick   <= 1'b0;
    end else if (!run) begin
      preCnt <= 8'h00;
      divCnt <= 8'h00;
      tick   <= 1'b0;
    end else begin
      tick   <= preLast && divLast;
      preCnt <= preLast ? 8'h00 : preCnt + 8'h01;
      if (preLast) begin
        divCnt <= divLast ? 8'h00 : divCnt + 8'h01;
      end
    end
  end
endmodule // ssp_rate

// ==== sim/ssp_port_sva.sv ====
// Checker: register answers, pin drive by mode and master link timing.
`timescale 1ns/1ps
module ssp_port_sva #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [15:0] writeData,
  input wire logic        writeStrobe,
  input wire logic        readStrobe,
  input wire logic [15:0] readData,
  // Pins
  input wire logic        sclkIn,
  input wire logic        sclkOut,
  input wire logic        sclkOe,
  input wire logic        frameIn,
  input wire logic        frameOut,
  input wire logic        frameOe,
  input wire logic        rxdIn,
  input wire logic        txdOut,
  input wire logic        txdOe
);
  // ==========================================================================
  // Shadow of the settings, kept from the write strobes alone
  logic [15:0] c0;
  logic [2:0]  c1;
  logic [7:0]  pre;
  logic [16:0] gap;
  logic [16:0] hiLen;
  logic [4:0]  rises;
  logic        sawRise;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c0  <= ssp_pkg::CTRL0_RST;
      c1  <= ssp_pkg::CTRL1_RST;
      pre <= ssp_pkg::PRESCALE_RST;
    end else if (writeStrobe) begin
      if (addr == ssp_pkg::OFF_CTRL0) c0 <= writeData;
      if (addr == ssp_pkg::OFF_CTRL1) c1 <= writeData[2:0];
      if (addr == ssp_pkg::OFF_PRESCALE) pre <= writeData[7:0];
    end
  end
  // Mode decode; prescale zero counts as one
  wire        mst  = c1[0] && !c1[1];
  wire        slv  = c1[0] && c1[1];
  wire        sod  = slv && c1[2];
  wire        spiM = mst && c0[5:4] == ssp_pkg::FMT_SPI;
  wire        ssfM = mst && c0[5:4] == ssp_pkg::FMT_SSF;
  wire        mwM  = mst && c0[5:4] == ssp_pkg::FMT_MW;
  wire        nmwM = mst && c0[5:4] != ssp_pkg::FMT_MW;
  wire [16:0] pEff = (pre == 8'h00) ? 17'h00001 : 17'(pre);
  wire [16:0] half = pEff * (17'(c0[15:8]) + 17'h00001);
  wire [4:0]  wid  = (c0[3:0] < 4'h3) ? 5'h04 : 5'(c0[3:0]) + 5'h01;
  // Edge spacing, frame high length and clock rises within one frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap     <= 17'h00000;
      hiLen   <= 17'h00000;
      rises   <= 5'h00;
      sawRise <= 1'b0;
    end else begin
      gap     <= ($changed(sclkOut) || $fell(frameOut)) ? 17'h00001 : gap + 17'h00001;
      hiLen   <= $rose(frameOut) ? 17'h00001 : hiLen + 17'h00001;
      rises   <= $fell(frameOut) ? 5'h00 : rises + 5'($rose(sclkOut));
      sawRise <= $rose(frameOut) || (sawRise && !$fell(frameOut));
    end
  end
  // ==========================================================================
  // Properties; mode terms look two cycles back since pins are registered
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence idleBus;
    !readStrobe;
  endsequence
  sequence missRead;
    readStrobe && addr > ssp_pkg::OFF_PRESCALE;
  endsequence
  a_read_one_cycle: assert property (idleBus |=> readData == 16'h0000)
    else $error("read data held beyond its cycle");
  a_unmapped_zero: assert property (missRead |=> readData == 16'h0000)
    else $error("unmapped read returned data");
  a_master_drives: assert property (mst && $past(mst, 2) |-> sclkOe && frameOe)
    else $error("master not driving clock and frame");
  a_slave_quiet: assert property (slv && $past(slv, 2) |-> !sclkOe && !frameOe)
    else $error("slave drives clock or frame");
  a_slave_no_txd: assert property (sod && $past(sod, 2) |-> !txdOe)
    else $error("disabled slave drives data");
  a_master_txd_on: assert property (nmwM && $past(nmwM, 2) |-> txdOe)
    else $error("master data output released");
  a_sclk_rate: assert property (spiM && !frameOut && $changed(sclkOut) |-> gap == half)
    else $error("serial clock half period wrong");
  a_frame_width: assert property (spiM && $past(spiM, 2) && $rose(frameOut) |-> rises == wid)
    else $error("clock count per frame wrong");
  a_ssf_pulse: assert property (ssfM && $past(ssfM, 2) && sawRise && $fell(frameOut)
    |-> hiLen == (half << 1))
    else $error("sync pulse not one bit long");
  a_mw_reply: assert property (mwM && $past(mwM, 2) && !txdOe |-> !frameOut)
    else $error("data released outside a frame");
endmodule // ssp_port_sva

bind ssp_port ssp_port_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_ssp_port_sva (
  .clk(clk), .rst(rst), .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData), .sclkIn(sclkIn), .sclkOut(sclkOut),
  .sclkOe(sclkOe), .frameIn(frameIn), .frameOut(frameOut), .frameOe(frameOe),
  .rxdIn(rxdIn), .txdOut(txdOut), .txdOe(txdOe)
);

// ==== sim/ssp_peer.sv ====
// Behavioural peripheral at the far end of the link, clock mode 0.
`timescale 1ns/1ps
module ssp_peer (
  // Link pins
  input  wire logic        sclk,
  input  wire logic        frame,
  input  wire logic        mosi,
  output logic             miso,
  // Reply word and word heard
  input  wire logic [15:0] reply,
  input  wire logic [3:0]  widM1,
  output logic [15:0]      got
);
  int bitNo = 0;
  initial miso = 1'b0;
  initial got = 16'h0000;
  // Frame start: top reply bit ready before the first edge
  always @(negedge frame) begin
    bitNo = int'(widM1);
    miso = reply[bitNo];
  end
  // Capture on the rising clock, beside our own reply
  always @(posedge sclk) if (!frame) got = {got[14:0], mosi};
  // Next reply bit on the falling clock
  always @(negedge sclk) if (!frame && bitNo > 0) begin
    bitNo--;
    miso = reply[bitNo];
  end
  // Released line shows the inverse, so a stale level never passes
  always @(posedge frame) miso = ~miso;
endmodule // ssp_peer

// ==== sim/ssp_port_bench.sv ====
// Self-checking bench for the serial port: registers, buffers, master link, slave pins.
`timescale 1ns/1ps
module ssp_port_bench;
  // ==========================================================================
  // Signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] writeData = 16'h0000;
  logic        writeStrobe = 1'b0;
  logic        readStrobe = 1'b0;
  logic        frameDrv = 1'b1;
  logic [15:0] reply = 16'h0000;
  logic [3:0]  widM1 = 4'h7;
  logic [15:0] readData, peerGot, rv, m;
  logic        sclkOut, sclkOe, frameOut, frameOe, rxd, txdOut, txdOe;
  int          failCount = 0, samplesChecked = 0;
  int          hiCnt = 0, oeLowCnt = 0;
  int          h0, o0;
  int          wTab[4] = '{4, 8, 16, 16};
  int          pTab[4] = '{2, 3, 1, 0};
  int          sTab[4] = '{3, 1, 4, 4};
  logic [7:0]  aTab[6] = '{ssp_pkg::OFF_CTRL0, ssp_pkg::OFF_CTRL1, ssp_pkg::OFF_PRESCALE,
                           ssp_pkg::OFF_STATUS, ssp_pkg::OFF_DATA, 8'h14};
  logic [15:0] eTab[6] = '{ssp_pkg::CTRL0_RST, 16'(ssp_pkg::CTRL1_RST),
                           16'(ssp_pkg::PRESCALE_RST), 16'h0003, 16'h0000, 16'h0000};
  // Pin levels from every party's enable; the bench's slave clock stands still
  wire sclkW  = sclkOe ? sclkOut : 1'b0;
  wire frameW = frameOe ? frameOut : frameDrv;
  ssp_port #(.FIFO_DEPTH(8)) i_ssp_port (
    .clk(clk), .rst(rst), .addr(addr), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .sclkIn(sclkW), .sclkOut(sclkOut), .sclkOe(sclkOe), .frameIn(frameW),
    .frameOut(frameOut), .frameOe(frameOe), .rxdIn(rxd), .txdOut(txdOut), .txdOe(txdOe)
  );
  ssp_peer i_ssp_peer (
    .sclk(sclkW), .frame(frameW), .mosi(txdOe ? txdOut : ~txdOut), .miso(rxd),
    .reply(reply), .widM1(widM1), .got(peerGot)
  );
  always #25 clk = ~clk;
  // Frame high and released data cycles, for the format checks
  always @(posedge clk) begin
    if (frameOut === 1'b1) hiCnt++;
    if (txdOe === 1'b0) oeLowCnt++;
  end
  // ==========================================================================
  // Bus tasks; an idle edge between strobes keeps one driver per time step
  task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask
  task automatic chkVal(input string n, input logic [15:0] e, input logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkBit(input string n, input logic e, input logic g);
    samplesChecked++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  // Poll a status bit under a bound of polls
  task automatic waitStat(input int b, input int n);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < n && s[b] !== 1'b1; i++) rdReg(ssp_pkg::OFF_STATUS, s);
    chkBit("status wait", 1'b1, s[b]);
  endtask
  task automatic reportAndStop();
    $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog: the tests need some 2300 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    reportAndStop();
  end
  // ==========================================================================
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wrReg(8'h14, 16'hFFFF);
    for (int k = 0; k < 6; k++) begin
      rdReg(aTab[k], rv);
      chkVal("reset value", eTab[k], rv);
    end
    $display("Test reset done");
    // Boundary widths and rates, prescale zero among them
    for (int k = 0; k < 4; k++) begin
      m = 16'hFFFF >> (16 - wTab[k]);
      widM1 <= 4'(wTab[k] - 1);
      reply <= 16'h5A3C & m;
      wrReg(ssp_pkg::OFF_PRESCALE, 16'(pTab[k]));
      wrReg(ssp_pkg::OFF_CTRL0, {8'(sTab[k]), 4'h0, 4'(wTab[k] - 1)});
      wrReg(ssp_pkg::OFF_CTRL1, 16'h0001);
      wrReg(ssp_pkg::OFF_DATA, 16'hA5C3);
      waitStat(ssp_pkg::ST_RNE, 200);
      rdReg(ssp_pkg::OFF_DATA, rv);
      chkVal("rx word", 16'h5A3C & m, rv);
      chkVal("peer word", 16'hA5C3 & m, peerGot & m);
      chkBit("frame idle", 1'b1, frameOut);
    end
    $display("Test frames done");
    // Fill the transmit buffer past its depth while stopped, drain late
    wrReg(ssp_pkg::OFF_CTRL1, 16'h0000);
    wrReg(ssp_pkg::OFF_CTRL0, 16'h0307);
    wrReg(ssp_pkg::OFF_PRESCALE, 16'h0002);
    widM1 <= 4'h7;
    reply <= 16'h0081;
    for (int i = 0; i < 9; i++) wrReg(ssp_pkg::OFF_DATA, 16'h0010 + 16'(i));
    rdReg(ssp_pkg::OFF_STATUS, rv);
    chkVal("tx full status", 16'h0000, rv & 16'h000F);
    wrReg(ssp_pkg::OFF_CTRL1, 16'h0001);
    waitStat(ssp_pkg::ST_RFF, 600);
    rdReg(ssp_pkg::OFF_STATUS, rv);
    chkVal("rx full status", 16'h000F, rv & 16'h000F);
    chkVal("peer last", 16'h0017, peerGot & 16'h00FF);
    for (int i = 0; i < 8; i++) begin
      rdReg(ssp_pkg::OFF_DATA, rv);
      chkVal("rx drained", 16'h0081, rv);
    end
    rdReg(ssp_pkg::OFF_STATUS, rv);
    chkVal("empty status", 16'h0003, rv & 16'h000F);
    $display("Test buffers done");
    // Sync pulse and turnaround formats
    for (int k = 0; k < 2; k++) begin
      wrReg(ssp_pkg::OFF_CTRL1, 16'h0000);
      wrReg(ssp_pkg::OFF_CTRL0, k ? 16'h0327 : 16'h0317);
      wrReg(ssp_pkg::OFF_CTRL1, 16'h0001);
      repeat (4) @(negedge clk);
      chkBit("format idle", k ? 1'b1 : 1'b0, frameOut);
      h0 = hiCnt;
      o0 = oeLowCnt;
      wrReg(ssp_pkg::OFF_DATA, 16'h00C3);
      waitStat(ssp_pkg::ST_RNE, 300);
      rdReg(ssp_pkg::OFF_DATA, rv);
      chkBit("format shape", 1'b1, k ? (oeLowCnt != o0) : (hiCnt != h0));
    end
    $display("Test formats done");
    // Slave pins with and without output disable
    wrReg(ssp_pkg::OFF_CTRL1, 16'h0007);
    frameDrv <= 1'b0;
    repeat (8) @(negedge clk);
    chkBit("slave data drive", 1'b0, txdOe);
    chkBit("slave clock drive", 1'b0, sclkOe | frameOe);
    wrReg(ssp_pkg::OFF_CTRL1, 16'h0003);
    repeat (8) @(negedge clk);
    chkBit("slave data drive", 1'b1, txdOe);
    @(posedge clk);
    frameDrv <= 1'b1;
    $display("Test slave done");
    reportAndStop();
  end
endmodule // ssp_port_bench
